// [hw/mam_alarm_monitor.sv]
// alarm supervision: two no-transition monitors, two carrier monitors,
// common lamp and strap-selected synchroniser inhibit
// assumes all inputs synchronous to MCLK_IN; alarm outputs active low
`include "mam_map.svh"

module mam_alarm_monitor
  import mam_pkg::*;
#(
  parameter int TICK_CYCLES = `MAM_TICK_CYC
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic SEND_DATA_IN,
  input wire logic RECV_DATA_IN,
  input wire logic TX_CARRIER_OK_IN,
  input wire logic RX_CARRIER_OK_IN,
  input wire logic ALARM_DISABLE_SWITCH_IN,
  input wire logic TALK_REQUEST_IN,
  input wire logic TALK_DETECTED_IN,
  input wire logic TALK_RESET_IN,
  input wire logic SYNC_STRAP_SEL_IN,
  output logic COMMON_ALARM_LAMP_N_OUT,
  output logic SEND_IDLE_ALARM_N_OUT,
  output logic TX_CARRIER_LOSS_N_OUT,
  output logic RECEIVE_IDLE_ALARM_N_OUT,
  output logic RX_CARRIER_LOSS_N_OUT,
  output logic SYNC_INHIBIT_N_OUT
);

  // ************************************************************
  // millisecond tick
  // ************************************************************
  mam_div_t div_ff;
  logic tick_ff;
  logic div_wrap;
  mam_div_t nxt_div;

  assign div_wrap = (div_ff == mam_div_t'(TICK_CYCLES - 1));
  assign nxt_div = div_wrap ? '0 : div_ff + 18'h00001;

  // free-running, so a timer started mid-period loses up to one tick
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_ff <= '0;
      tick_ff <= 1'h0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= div_wrap; // [RL23]
    end
  end

  // ************************************************************
  // transition detect and talk states
  // ************************************************************
  logic send_prev_ff;
  logic recv_prev_ff;
  logic talk_gen_state_ff;
  logic talk_detect_state_ff;
  logic send_edge;
  logic recv_edge;
  logic nxt_talk_gen;
  logic nxt_talk_det;

  assign send_edge = SEND_DATA_IN ^ send_prev_ff; // [RL5]
  assign recv_edge = RECV_DATA_IN ^ recv_prev_ff; // [RL12]
  // a request in the reset cycle wins over the reset
  assign nxt_talk_gen = TALK_REQUEST_IN | (talk_gen_state_ff & ~TALK_RESET_IN); // [RL21]
  assign nxt_talk_det = TALK_DETECTED_IN | (talk_detect_state_ff & ~TALK_RESET_IN); // [RL22]

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      send_prev_ff <= 1'h0;
      recv_prev_ff <= 1'h0;
      talk_gen_state_ff <= `MAM_RST_TALK;
      talk_detect_state_ff <= `MAM_RST_TALK;
    end else begin
      send_prev_ff <= SEND_DATA_IN;
      recv_prev_ff <= RECV_DATA_IN;
      talk_gen_state_ff <= nxt_talk_gen;
      talk_detect_state_ff <= nxt_talk_det;
    end
  end

  // ************************************************************
  // four monitors
  // ************************************************************
  logic [3:0] absent;
  logic [3:0] inhibit;
  logic [3:0] nxt_alarm;
  mam_gap_t gap_ff [4];
  mam_tmr_t tmr_ff [4];
  mam_gap_t nxt_gap [4];
  mam_tmr_t nxt_tmr [4];
  logic alarm_n_ff [4];

  assign absent[MAM_SEND_IDLE] = ~send_edge; // [RL5]
  assign absent[MAM_TX_CARR] = ~TX_CARRIER_OK_IN; // [RL9]
  assign absent[MAM_RECV_IDLE] = ~recv_edge; // [RL12]
  assign absent[MAM_RX_CARR] = ~RX_CARRIER_OK_IN; // [RL15]

  assign inhibit[MAM_SEND_IDLE] = ALARM_DISABLE_SWITCH_IN | talk_gen_state_ff; // [RL4] [RL8]
  assign inhibit[MAM_TX_CARR] = ALARM_DISABLE_SWITCH_IN | talk_gen_state_ff; // [RL11]
  assign inhibit[MAM_RECV_IDLE] = ALARM_DISABLE_SWITCH_IN | talk_detect_state_ff; // [RL14]
  assign inhibit[MAM_RX_CARR] = ALARM_DISABLE_SWITCH_IN | talk_detect_state_ff; // [RL17]

  for (genvar i = 0; i < 4; i++) begin : g_mon
    // idle monitors: gap stage then 5 s stage; carrier: one stage,
    // one tick beyond 2 s so a 2 s dropout never alarms
    localparam bit IDLE = (i == MAM_SEND_IDLE) || (i == MAM_RECV_IDLE);
    localparam mam_gap_t GL = IDLE ? 8'(`MAM_GAP_TICKS) : 8'h00;
    localparam mam_tmr_t TL = IDLE ? 13'(`MAM_IDLE_TICKS) : 13'(`MAM_CARR_TICKS + 1);
    logic restart;
    logic gap_full;

    assign restart = ~absent[i] | inhibit[i]; // [RL6] [RL24]
    assign gap_full = (gap_ff[i] == GL);
    assign nxt_gap[i] = restart ? '0 :
                        (tick_ff && !gap_full) ? gap_ff[i] + 8'h01 : gap_ff[i]; // [RL6]
    assign nxt_tmr[i] = restart ? '0 :
                        (tick_ff && gap_full && tmr_ff[i] != TL) ?
                        tmr_ff[i] + 13'h0001 : tmr_ff[i]; // [RL1] [RL2] [RL23]
    assign nxt_alarm[i] = mam_expired(nxt_gap[i], nxt_tmr[i], GL, TL);

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
        gap_ff[i] <= '0;
        tmr_ff[i] <= '0;
        alarm_n_ff[i] <= `MAM_RST_ALARM_N;
      end else begin
        gap_ff[i] <= nxt_gap[i];
        tmr_ff[i] <= nxt_tmr[i];
        alarm_n_ff[i] <= ~nxt_alarm[i]; // [RL7] [RL10] [RL13] [RL16]
      end
    end
  end

  // ************************************************************
  // common lamp and synchroniser inhibit
  // ************************************************************
  logic lamp_n_ff;
  logic sync_n_ff;
  logic any_alarm;
  logic sync_cause;

  assign any_alarm = |nxt_alarm; // [RL3] [RL18]
  // alternate strap takes the raw carrier loss, ahead of any inhibit
  assign sync_cause = SYNC_STRAP_SEL_IN ? ~RX_CARRIER_OK_IN : any_alarm; // [RL19] [RL20]

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lamp_n_ff <= `MAM_RST_ALARM_N;
      sync_n_ff <= `MAM_RST_ALARM_N;
    end else begin
      lamp_n_ff <= ~any_alarm; // [RL18]
      sync_n_ff <= ~sync_cause;
    end
  end

  assign COMMON_ALARM_LAMP_N_OUT = lamp_n_ff;
  assign SEND_IDLE_ALARM_N_OUT = alarm_n_ff[MAM_SEND_IDLE];
  assign TX_CARRIER_LOSS_N_OUT = alarm_n_ff[MAM_TX_CARR];
  assign RECEIVE_IDLE_ALARM_N_OUT = alarm_n_ff[MAM_RECV_IDLE];
  assign RX_CARRIER_LOSS_N_OUT = alarm_n_ff[MAM_RX_CARR];
  assign SYNC_INHIBIT_N_OUT = sync_n_ff;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  sequence s_tick_expiry(int m);
    $past(tick_ff) ##0 (tmr_ff[m] != $past(tmr_ff[m]));
  endsequence

  a_disable_all_off: assert property (ALARM_DISABLE_SWITCH_IN |=> // [RL4]
    (COMMON_ALARM_LAMP_N_OUT && SEND_IDLE_ALARM_N_OUT && TX_CARRIER_LOSS_N_OUT
     && RECEIVE_IDLE_ALARM_N_OUT && RX_CARRIER_LOSS_N_OUT))
    else $error("alarm active while disabled");

  a_common_lamp_or: assert property (COMMON_ALARM_LAMP_N_OUT == // [RL3] [RL18]
    (SEND_IDLE_ALARM_N_OUT && TX_CARRIER_LOSS_N_OUT
     && RECEIVE_IDLE_ALARM_N_OUT && RX_CARRIER_LOSS_N_OUT))
    else $error("common lamp not the OR of four alarms");

  a_sync_common: assert property (!$past(SYNC_STRAP_SEL_IN) |-> // [RL19]
    SYNC_INHIBIT_N_OUT == COMMON_ALARM_LAMP_N_OUT)
    else $error("sync inhibit does not follow common alarm");

  a_sync_fast: assert property ((SYNC_STRAP_SEL_IN && !RX_CARRIER_OK_IN) |=> // [RL20]
    !SYNC_INHIBIT_N_OUT)
    else $error("sync inhibit late on carrier loss");

  a_send_edge_clear: assert property (send_edge |=> // [RL5] [RL6] [RL24]
    (SEND_IDLE_ALARM_N_OUT && gap_ff[MAM_SEND_IDLE] == 8'h00))
    else $error("send edge did not restart monitor");

  a_send_expiry_time: assert property ($fell(SEND_IDLE_ALARM_N_OUT) |-> // [RL1] [RL7]
    (gap_ff[MAM_SEND_IDLE] == 8'(`MAM_GAP_TICKS)
    && tmr_ff[MAM_SEND_IDLE] == 13'(`MAM_IDLE_TICKS)) and s_tick_expiry(MAM_SEND_IDLE))
    else $error("send idle alarm at wrong count");

  a_recv_expiry_time: assert property ($fell(RECEIVE_IDLE_ALARM_N_OUT) |-> // [RL12] [RL13]
    gap_ff[MAM_RECV_IDLE] == 8'(`MAM_GAP_TICKS)
    && tmr_ff[MAM_RECV_IDLE] == 13'(`MAM_IDLE_TICKS))
    else $error("receive idle alarm at wrong count");

  a_tx_carr_time: assert property ($fell(TX_CARRIER_LOSS_N_OUT) |-> // [RL2] [RL10]
    tmr_ff[MAM_TX_CARR] == 13'(`MAM_CARR_TICKS + 1) && !$past(TX_CARRIER_OK_IN, 2))
    else $error("tx carrier alarm at wrong count");

  a_rx_carr_time: assert property ($fell(RX_CARRIER_LOSS_N_OUT) |-> // [RL16]
    tmr_ff[MAM_RX_CARR] == 13'(`MAM_CARR_TICKS + 1) and s_tick_expiry(MAM_RX_CARR))
    else $error("rx carrier alarm at wrong count");

  a_tx_restore: assert property (TX_CARRIER_OK_IN |=> // [RL9] [RL24]
    (TX_CARRIER_LOSS_N_OUT && tmr_ff[MAM_TX_CARR] == 13'h0000))
    else $error("tx carrier return did not clear");

  a_rx_restore: assert property (RX_CARRIER_OK_IN |=> // [RL15]
    (RX_CARRIER_LOSS_N_OUT && tmr_ff[MAM_RX_CARR] == 13'h0000))
    else $error("rx carrier return did not clear");

  a_talk_gen_inh: assert property (talk_gen_state_ff |=> // [RL8] [RL11]
    (SEND_IDLE_ALARM_N_OUT && TX_CARRIER_LOSS_N_OUT))
    else $error("send alarms not inhibited by talk request");

  a_talk_det_inh: assert property (talk_detect_state_ff |=> // [RL14] [RL17]
    (RECEIVE_IDLE_ALARM_N_OUT && RX_CARRIER_LOSS_N_OUT))
    else $error("receive alarms not inhibited by talk detect");

  a_talk_gen_hold: assert property ((talk_gen_state_ff && !TALK_RESET_IN) |=> // [RL21]
    talk_gen_state_ff)
    else $error("talk generator state dropped early");

  a_talk_det_hold: assert property ((talk_detect_state_ff && !TALK_RESET_IN) |=> // [RL22]
    talk_detect_state_ff)
    else $error("talk detect state dropped early");

  a_tick_single: assert property (tick_ff |=> !tick_ff) // [RL23]
    else $error("tick wider than one cycle");

  sequence s_recv_restart;
    RECEIVE_IDLE_ALARM_N_OUT && gap_ff[MAM_RECV_IDLE] == 8'h00
      && tmr_ff[MAM_RECV_IDLE] == 13'h0000;
  endsequence

  a_recv_edge_clear: assert property (recv_edge |=> s_recv_restart) // [RL12] [RL24]
    else $error("receive edge did not restart monitor");

  // the 5 s stage must not move before the gap stage has filled
  a_send_gap_first: assert property (gap_ff[MAM_SEND_IDLE] != 8'(`MAM_GAP_TICKS) |-> // [RL6]
    tmr_ff[MAM_SEND_IDLE] == 13'h0000)
    else $error("send timer ran before gap filled");

  a_recv_gap_first: assert property (gap_ff[MAM_RECV_IDLE] != 8'(`MAM_GAP_TICKS) |-> // [RL12]
    tmr_ff[MAM_RECV_IDLE] == 13'h0000)
    else $error("receive timer ran before gap filled");

  a_send_alarm_hold: assert property (!SEND_IDLE_ALARM_N_OUT |-> // [RL1] [RL7]
    tmr_ff[MAM_SEND_IDLE] == 13'(`MAM_IDLE_TICKS))
    else $error("send idle alarm without full count");

  a_recv_alarm_hold: assert property (!RECEIVE_IDLE_ALARM_N_OUT |-> // [RL13]
    tmr_ff[MAM_RECV_IDLE] == 13'(`MAM_IDLE_TICKS))
    else $error("receive idle alarm without full count");

  a_tx_alarm_hold: assert property (!TX_CARRIER_LOSS_N_OUT |-> // [RL2] [RL10]
    tmr_ff[MAM_TX_CARR] == 13'(`MAM_CARR_TICKS + 1))
    else $error("tx carrier alarm without full count");

  a_rx_alarm_hold: assert property (!RX_CARRIER_LOSS_N_OUT |-> // [RL2] [RL16]
    tmr_ff[MAM_RX_CARR] == 13'(`MAM_CARR_TICKS + 1))
    else $error("rx carrier alarm without full count");

  a_tx_inhibit_clear: assert property (inhibit[MAM_TX_CARR] |=> // [RL11] [RL23]
    tmr_ff[MAM_TX_CARR] == 13'h0000)
    else $error("tx carrier timer not cleared by inhibit");

  a_rx_inhibit_clear: assert property (inhibit[MAM_RX_CARR] |=> // [RL17] [RL23]
    tmr_ff[MAM_RX_CARR] == 13'h0000)
    else $error("rx carrier timer not cleared by inhibit");

  a_talk_gen_set: assert property (TALK_REQUEST_IN |=> talk_gen_state_ff) // [RL21]
    else $error("talk request did not set generator state");

  a_talk_det_set: assert property (TALK_DETECTED_IN |=> talk_detect_state_ff) // [RL22]
    else $error("talk detect did not set detect state");

  a_talk_reset_clear: assert property ((TALK_RESET_IN && !TALK_REQUEST_IN // [RL21] [RL22]
    && !TALK_DETECTED_IN) |=> (!talk_gen_state_ff && !talk_detect_state_ff))
    else $error("talk reset did not clear talk states");

  a_tick_aligned: assert property (tick_ff |-> div_ff == 18'h00000) // [RL23]
    else $error("tick not aligned with divider wrap");

  a_sync_recover: assert property ((SYNC_STRAP_SEL_IN && RX_CARRIER_OK_IN) |=> // [RL20]
    SYNC_INHIBIT_N_OUT)
    else $error("sync inhibit held with carrier present");

endmodule

// [include/mam_map.svh]
// constants for the modem alarm monitor: timing, limits, reset values
// assumes a 200 MHz system clock and a 1 ms internal tick
//
// Contract
// RL1: raise no-transition alarm after five seconds without a data transition
// RL2: raise carrier alarm only if carrier absent longer than two seconds
// RL3: common alarm active when any of the four alarms is active
// RL4: disable switch holds all four monitors and the common alarm off
// RL5: send transition detector counts rising and falling data edges
// RL6: send gap over 200 ms starts 5 s timer; next edge resets both
// RL7: send 5 s expiry raises common alarm, drives send idle output low
// RL8: send idle alarm inhibited by disable switch or talk generator state
// RL9: tx carrier loss starts 2 s timer; early return clears it silently
// RL10: tx carrier 2 s expiry raises common alarm, drives tx loss low
// RL11: tx carrier alarm inhibited by switch or talk generator state
// RL12: receive transitions restart gap; 200 ms gap starts 5 s timer
// RL13: receive 5 s expiry raises common alarm, drives receive idle low
// RL14: receive idle alarm inhibited by switch or talk detected state
// RL15: rx carrier loss starts 2 s timer; return within it clears it
// RL16: rx carrier 2 s expiry raises common alarm, drives rx loss low
// RL17: rx carrier alarm inhibited by switch or talk detected state
// RL18: four alarms are ORed; common lamp output is active low
// RL19: first strap: sync inhibit output low while common alarm active
// RL20: alternate strap: sync inhibit low at once on rx carrier loss
// RL21: talk generator inhibit holds from talk request until talk reset
// RL22: talk detected state clears only on talk reset
// RL23: intervals are tick counters, cleared by reset and inhibits
// RL24: each alarm drops as soon as condition clears or inhibit applies
`ifndef MAM_MAP_SVH
`define MAM_MAP_SVH

`define MAM_CLK_NS 5
`define MAM_TICK_NS 1000000
`define MAM_TICK_CYC (`MAM_TICK_NS / `MAM_CLK_NS)

`define MAM_GAP_MS 200
`define MAM_IDLE_MS 5000
`define MAM_CARR_MS 2000
// divide the tick down first: 5000 ms times 1e6 would overflow a 32-bit int
`define MAM_GAP_TICKS (`MAM_GAP_MS / (`MAM_TICK_NS / 1000000))
`define MAM_IDLE_TICKS (`MAM_IDLE_MS / (`MAM_TICK_NS / 1000000))
`define MAM_CARR_TICKS (`MAM_CARR_MS / (`MAM_TICK_NS / 1000000))

`define MAM_RST_ALARM_N 1'h1
`define MAM_RST_TALK 1'h0

`endif

// [include/mam_pkg.sv]
// types shared by the modem alarm monitor
// assumes mam_map.svh supplies the numeric constants
package mam_pkg;

  typedef enum {MAM_SEND_IDLE, MAM_TX_CARR, MAM_RECV_IDLE, MAM_RX_CARR} mam_mon_t;
  typedef logic [7:0] mam_gap_t;
  typedef logic [12:0] mam_tmr_t;
  typedef logic [17:0] mam_div_t;

  function automatic logic mam_expired(mam_gap_t g, mam_tmr_t t, mam_gap_t gl, mam_tmr_t tl);
    return (g == gl) && (t == tl);
  endfunction

endpackage

// [testbench/mam_line_partner.sv]
// ****************************************
// line partner: far-end data sources
// ****************************************
// toggles send and receive data every eight clocks while its run input is high;
// assumes the bench owns carrier, switch and talk controls
module mam_line_partner (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic send_run_in,
  input wire logic recv_run_in,
  output logic send_data_out,
  output logic recv_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_ff;
  // a stalled line simply holds its level, as a dead circuit would
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_ff <= 3'h0;
      send_data_out <= 1'h0;
      recv_data_out <= 1'h0;
    end else begin
      phase_ff <= phase_ff + 3'h1;
      if (phase_ff == 3'h7 && send_run_in) send_data_out <= ~send_data_out;
      if (phase_ff == 3'h7 && recv_run_in) recv_data_out <= ~recv_data_out;
    end
  end
endmodule

// [testbench/testbench.sv]
// ****************************************
// alarm monitor bench: carrier table, then idle and inhibit cases
// ****************************************
// assumes the tick is shrunk to four clocks; result bits are
// {lamp, send idle, tx loss, recv idle, rx loss, sync}, all active low
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  typedef struct packed {logic tx; logic rx; logic ds; logic st; logic [5:0] ex;} mam_row_t;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic tx_ok = 1'h1;
  logic rx_ok = 1'h1;
  logic dis = 1'h0;
  logic t_req = 1'h0;
  logic t_det = 1'h0;
  logic t_rst = 1'h0;
  logic strap = 1'h0;
  logic s_run = 1'h1;
  logic r_run = 1'h1;
  logic s_dat, r_dat, lamp_n, s_n, tx_n, r_n, rx_n, sy_n;
  int n_errors = 0;
  int n_tests = 0;
  mam_row_t rows [4] = '{'{1'h0, 1'h1, 1'h0, 1'h0, 6'h16}, '{1'h1, 1'h0, 1'h0, 1'h1, 6'h1C},
                         '{1'h0, 1'h1, 1'h1, 1'h0, 6'h3F}, '{1'h1, 1'h0, 1'h1, 1'h1, 6'h3E}};

  always #2.5 mclk = ~mclk;

  mam_line_partner line (.clk_in(mclk), .rst_n_in(rst_n), .send_run_in(s_run),
    .recv_run_in(r_run), .send_data_out(s_dat), .recv_data_out(r_dat));

  mam_alarm_monitor #(.TICK_CYCLES(TK)) dut (.MCLK_IN(mclk), .RST_N_IN(rst_n),
    .SEND_DATA_IN(s_dat), .RECV_DATA_IN(r_dat), .TX_CARRIER_OK_IN(tx_ok),
    .RX_CARRIER_OK_IN(rx_ok), .ALARM_DISABLE_SWITCH_IN(dis), .TALK_REQUEST_IN(t_req),
    .TALK_DETECTED_IN(t_det), .TALK_RESET_IN(t_rst), .SYNC_STRAP_SEL_IN(strap),
    .COMMON_ALARM_LAMP_N_OUT(lamp_n), .SEND_IDLE_ALARM_N_OUT(s_n),
    .TX_CARRIER_LOSS_N_OUT(tx_n), .RECEIVE_IDLE_ALARM_N_OUT(r_n),
    .RX_CARRIER_LOSS_N_OUT(rx_n), .SYNC_INHIBIT_N_OUT(sy_n));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // looks just after the edge, then returns on the next edge so drives stay edge aligned
  task automatic chk(input logic [5:0] ex, input string what);
    #1;
    n_tests++;
    if ({lamp_n, s_n, tx_n, r_n, rx_n, sy_n} !== ex) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %b want %b", $time, what,
               {lamp_n, s_n, tx_n, r_n, rx_n, sy_n}, ex);
    end
    @(posedge mclk);
  endtask

  task automatic report_and_stop();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    // the tests take about 90k clocks
    #(98000 * 5);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    cyc(4);
    rst_n <= 1'h1;
    cyc(1);
    chk(6'h3F, "after reset");
    foreach (rows[i]) begin
      tx_ok <= rows[i].tx;
      rx_ok <= rows[i].rx;
      dis <= rows[i].ds;
      strap <= rows[i].st;
      cyc(2001 * TK + 8);
      chk(rows[i].ex, "carrier row");
      tx_ok <= 1'h1;
      rx_ok <= 1'h1;
      dis <= 1'h0;
      strap <= 1'h0;
      cyc(2);
      chk(6'h3F, "carrier back");
    end
    // a loss one clock short of two seconds must stay quiet
    tx_ok <= 1'h0;
    cyc(2000 * TK - 2);
    chk(6'h3F, "short tx loss");
    tx_ok <= 1'h1;
    strap <= 1'h1;
    rx_ok <= 1'h0;
    cyc(2);
    chk(6'h3E, "sync at once");
    rx_ok <= 1'h1;
    strap <= 1'h0;
    cyc(2);
    chk(6'h3F, "sync back");
    s_run <= 1'h0;
    r_run <= 1'h0;
    cyc(5195 * TK);
    chk(6'h3F, "idle early");
    cyc(6 * TK + 8);
    chk(6'h0A, "idle alarm");
    s_run <= 1'h1;
    cyc(12);
    chk(6'h1A, "send resumes");
    r_run <= 1'h1;
    cyc(12);
    chk(6'h3F, "recv resumes");
    // talk states latch from one-cycle pulses; a request alone guards only the send side
    t_req <= 1'h1;
    cyc(1);
    t_req <= 1'h0;
    s_run <= 1'h0;
    r_run <= 1'h0;
    tx_ok <= 1'h0;
    rx_ok <= 1'h0;
    cyc(2001 * TK + 12);
    chk(6'h1C, "talk request only");
    t_det <= 1'h1;
    cyc(1);
    t_det <= 1'h0;
    cyc(3200 * TK);
    chk(6'h3F, "talk inhibit");
    t_rst <= 1'h1;
    cyc(1);
    t_rst <= 1'h0;
    cyc(2001 * TK + 12);
    chk(6'h14, "after talk reset");
    s_run <= 1'h1;
    r_run <= 1'h1;
    tx_ok <= 1'h1;
    rx_ok <= 1'h1;
    cyc(12);
    chk(6'h3F, "all clear");
    report_and_stop();
  end
endmodule
